// *** rtl/fpec_pkg.sv ***
// constants and types for the non-volatile program and erase controller
package fpec_pkg;

  // register offsets on the host register port
  localparam logic [7:0] OFS_NVM_SEQUENTIAL_READ_PORT = 8'h05;
  localparam logic [7:0] OFS_NVM_BYTE_DATA_PORT = 8'h06;
  localparam logic [7:0] OFS_NVM_UNLOCK_KEY_PORT = 8'h67;
  localparam logic [7:0] OFS_NVM_ADDR_LOW = 8'h68;
  localparam logic [7:0] OFS_NVM_ADDR_HIGH = 8'h69;
  localparam logic [7:0] OFS_NVM_PAGE_ERASE_TRIGGER = 8'h6a;
  localparam logic [7:0] OFS_NVM_OP_STATUS = 8'h7b;

  // key codes and command values
  localparam logic [7:0] KEY_FIRST = 8'ha5;
  localparam logic [7:0] KEY_SECOND = 8'hf1;
  localparam logic [7:0] ERASE_GO = 8'h01;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // status field positions
  localparam int STS_BUSY_BIT = 3;
  localparam int STS_LAST_WRITE_BIT = 1;
  localparam int STS_LAST_ERASE_BIT = 0;

  // reset values
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // array geometry
  localparam int MEM_BYTES = 8192;
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 9;
  localparam int PAGE_BYTES = 512;
  localparam logic [ADDR_W-1:0] FACTORY_BASE = 13'h1ffa;
  localparam int FACTORY_BYTES = 6;

  // operation timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_TIME_NS = 55000;
  localparam int ERASE_TIME_NS = 11000000;
  localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES_DEFAULT = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;

  typedef enum logic [1:0] {
    KEY_SHUT,
    KEY_HALF,
    KEY_OPEN,
    KEY_BARRED
  } fpec_key_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_WRITE,
    OP_ERASE
  } fpec_op_t;

endpackage

// *** rtl/fpec_ctrl.sv ***
// non-volatile byte program, page erase and read controller
//
// Notes on behaviour
// - factory network address in top six bytes
// - address most significant byte at lowest location
// - last page erases like any other
// - one byte programmed per host write
// - writes only clear bits to zero
// - erase clears a whole 512-byte page
// - internal timing, host port never stalls
// - other registers served while busy
// - completion raises an interrupt request
// - status shows progress; host polls or waits
// - reads allowed in any lock state
// - key 0xA5 then 0xF1 unlocks
// - one unlock covers one operation only
// - unkeyed attempt while idle blocks writes until reset
// - erase targets page holding the address
// - writing 0x01 to trigger starts erase
// - writing data port starts byte write
// - busy bit 3 set during any operation
// - bit 1 last write, bit 0 last erase
// - sequential read returns byte, increments address
// - address split into high and low bytes
`timescale 1ns/1ps

module fpec_ctrl #(
  parameter int ERASE_CYCLES = fpec_pkg::ERASE_CYCLES_DEFAULT,
  // arbitrary value, overwritten in production
  parameter logic [47:0] FACTORY_NET_ADDR = 48'h02_12_34_56_78_9a
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic nvmDoneIrq
);

  localparam logic [fpec_pkg::CNT_W-1:0] WRITE_LAST =
    fpec_pkg::CNT_W'(fpec_pkg::WRITE_CYCLES - 1);
  localparam logic [fpec_pkg::CNT_W-1:0] ERASE_LAST =
    fpec_pkg::CNT_W'(ERASE_CYCLES - 1);
  localparam logic [fpec_pkg::CNT_W-1:0] PAGE_END =
    fpec_pkg::CNT_W'(fpec_pkg::PAGE_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rstMeta_r;
  logic rstSyncN_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstMeta_r <= 1'b0;
      rstSyncN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN_r <= rstMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage array

  logic [7:0] mem [fpec_pkg::MEM_BYTES];
  logic memWe;
  logic [fpec_pkg::ADDR_W-1:0] memWAddr;
  logic [7:0] memWData;

  // contents survive reset; power-up image is erased plus factory address
  initial begin
    for (int i = 0; i < fpec_pkg::MEM_BYTES; i++) begin
      mem[i] = fpec_pkg::ERASED_BYTE;
    end
    for (int j = 0; j < fpec_pkg::FACTORY_BYTES; j++) begin
      mem[int'(fpec_pkg::FACTORY_BASE) + j] = FACTORY_NET_ADDR[(47 - 8 * j) -: 8];
    end
  end

  // plain always: the power-up image above also writes this array
  always @(posedge clk_sys) begin
    if (memWe) begin
      mem[memWAddr] <= memWData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  logic keyWr;
  logic addrHighWr;
  logic addrLowWr;
  logic trigWrite;
  logic trigErase;
  logic seqRd;

  always_comb begin
    keyWr = regWrEn && (regAddr == fpec_pkg::OFS_NVM_UNLOCK_KEY_PORT);
    addrHighWr = regWrEn && (regAddr == fpec_pkg::OFS_NVM_ADDR_HIGH);
    addrLowWr = regWrEn && (regAddr == fpec_pkg::OFS_NVM_ADDR_LOW);
    trigWrite = regWrEn && (regAddr == fpec_pkg::OFS_NVM_BYTE_DATA_PORT);
    trigErase = regWrEn && (regAddr == fpec_pkg::OFS_NVM_PAGE_ERASE_TRIGGER)
      && (regWrData == fpec_pkg::ERASE_GO);
    seqRd = regRdEn && (regAddr == fpec_pkg::OFS_NVM_SEQUENTIAL_READ_PORT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // lock and key

  fpec_pkg::fpec_key_t keyState_r;
  fpec_pkg::fpec_key_t keyState_nxt;
  fpec_pkg::fpec_op_t opState_r;
  logic startOp;

  always_comb begin
    keyState_nxt = keyState_r;
    startOp = 1'b0;
    if ((trigWrite || trigErase) && (opState_r == fpec_pkg::OP_IDLE)) begin
      if (keyState_r == fpec_pkg::KEY_OPEN) begin
        startOp = 1'b1;
        keyState_nxt = fpec_pkg::KEY_SHUT;
      end else begin
        keyState_nxt = fpec_pkg::KEY_BARRED;
      end
    end else if (keyWr) begin
      case (keyState_r)
        fpec_pkg::KEY_SHUT,
        fpec_pkg::KEY_OPEN: begin
          keyState_nxt = (regWrData == fpec_pkg::KEY_FIRST) ?
            fpec_pkg::KEY_HALF : fpec_pkg::KEY_SHUT;
        end
        fpec_pkg::KEY_HALF: begin
          if (regWrData == fpec_pkg::KEY_SECOND) begin
            keyState_nxt = fpec_pkg::KEY_OPEN;
          end else if (regWrData == fpec_pkg::KEY_FIRST) begin
            keyState_nxt = fpec_pkg::KEY_HALF;
          end else begin
            keyState_nxt = fpec_pkg::KEY_SHUT;
          end
        end
        fpec_pkg::KEY_BARRED: begin
          keyState_nxt = fpec_pkg::KEY_BARRED;
        end
        default: begin
          keyState_nxt = fpec_pkg::KEY_SHUT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      keyState_r <= fpec_pkg::KEY_SHUT;
    end else begin
      keyState_r <= keyState_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address pointer

  logic [7:0] addrHigh_r;
  logic [7:0] addrHigh_nxt;
  logic [7:0] addrLow_r;
  logic [7:0] addrLow_nxt;
  logic [fpec_pkg::ADDR_W-1:0] curAddr;

  always_comb begin
    addrHigh_nxt = addrHigh_r;
    addrLow_nxt = addrLow_r;
    if (addrHighWr) begin
      addrHigh_nxt = regWrData;
    end else if (addrLowWr) begin
      addrLow_nxt = regWrData;
    end else if (seqRd) begin
      {addrHigh_nxt, addrLow_nxt} = 16'({addrHigh_r, addrLow_r} + 16'h0001);
    end
    curAddr = {addrHigh_r[fpec_pkg::ADDR_W-9:0], addrLow_r};
  end

  always_ff @(posedge clk_sys or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      addrHigh_r <= fpec_pkg::ADDR_RESET;
      addrLow_r <= fpec_pkg::ADDR_RESET;
    end else begin
      addrHigh_r <= addrHigh_nxt;
      addrLow_r <= addrLow_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program and erase engine

  fpec_pkg::fpec_op_t opState_nxt;
  logic [fpec_pkg::CNT_W-1:0] opCnt_r;
  logic [fpec_pkg::CNT_W-1:0] opCnt_nxt;
  logic [fpec_pkg::ADDR_W-1:0] opAddr_r;
  logic [fpec_pkg::ADDR_W-1:0] opAddr_nxt;
  logic [7:0] opData_r;
  logic [7:0] opData_nxt;
  logic lastWrite_r;
  logic lastWrite_nxt;
  logic lastErase_r;
  logic lastErase_nxt;
  logic doneIrq_r;
  logic doneIrq_nxt;

  // the operation runs off its own counter; host strobes never wait on it
  always_comb begin
    opState_nxt = opState_r;
    opCnt_nxt = opCnt_r;
    opAddr_nxt = opAddr_r;
    opData_nxt = opData_r;
    lastWrite_nxt = lastWrite_r;
    lastErase_nxt = lastErase_r;
    doneIrq_nxt = 1'b0;
    memWe = 1'b0;
    memWAddr = opAddr_r;
    memWData = fpec_pkg::ERASED_BYTE;
    case (opState_r)
      fpec_pkg::OP_IDLE: begin
        if (startOp) begin
          opCnt_nxt = fpec_pkg::CNT_RESET;
          opAddr_nxt = curAddr;
          opData_nxt = regWrData;
          opState_nxt = trigWrite ? fpec_pkg::OP_WRITE : fpec_pkg::OP_ERASE;
        end
      end
      fpec_pkg::OP_WRITE: begin
        opCnt_nxt = opCnt_r + 1'b1;
        if (opCnt_r == WRITE_LAST) begin
          memWe = 1'b1;
          memWData = mem[opAddr_r] & opData_r;
          opState_nxt = fpec_pkg::OP_IDLE;
          lastWrite_nxt = 1'b1;
          lastErase_nxt = 1'b0;
          doneIrq_nxt = 1'b1;
        end
      end
      fpec_pkg::OP_ERASE: begin
        opCnt_nxt = opCnt_r + 1'b1;
        // no page is exempt, the factory page included
        if (opCnt_r < PAGE_END) begin
          memWe = 1'b1;
          memWAddr = {opAddr_r[fpec_pkg::ADDR_W-1:fpec_pkg::PAGE_W],
            opCnt_r[fpec_pkg::PAGE_W-1:0]};
        end
        if (opCnt_r == ERASE_LAST) begin
          opState_nxt = fpec_pkg::OP_IDLE;
          lastWrite_nxt = 1'b0;
          lastErase_nxt = 1'b1;
          doneIrq_nxt = 1'b1;
        end
      end
      default: begin
        opState_nxt = fpec_pkg::OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      opState_r <= fpec_pkg::OP_IDLE;
      opCnt_r <= fpec_pkg::CNT_RESET;
      opAddr_r <= '0;
      opData_r <= fpec_pkg::ERASED_BYTE;
      lastWrite_r <= 1'b0;
      lastErase_r <= 1'b0;
      doneIrq_r <= 1'b0;
    end else begin
      opState_r <= opState_nxt;
      opCnt_r <= opCnt_nxt;
      opAddr_r <= opAddr_nxt;
      opData_r <= opData_nxt;
      lastWrite_r <= lastWrite_nxt;
      lastErase_r <= lastErase_nxt;
      doneIrq_r <= doneIrq_nxt;
    end
  end

  assign nvmDoneIrq = doneIrq_r;

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic [7:0] statusByte;

  always_comb begin
    statusByte = 8'h00;
    statusByte[fpec_pkg::STS_BUSY_BIT] = (opState_r != fpec_pkg::OP_IDLE);
    statusByte[fpec_pkg::STS_LAST_WRITE_BIT] = lastWrite_r;
    statusByte[fpec_pkg::STS_LAST_ERASE_BIT] = lastErase_r;
    rdData_nxt = fpec_pkg::RDATA_RESET;
    if (regRdEn) begin
      // reads pass whatever the lock or engine state
      case (regAddr)
        fpec_pkg::OFS_NVM_SEQUENTIAL_READ_PORT,
        fpec_pkg::OFS_NVM_BYTE_DATA_PORT: begin
          rdData_nxt = mem[curAddr];
        end
        fpec_pkg::OFS_NVM_ADDR_HIGH: begin
          rdData_nxt = addrHigh_r;
        end
        fpec_pkg::OFS_NVM_ADDR_LOW: begin
          rdData_nxt = addrLow_r;
        end
        fpec_pkg::OFS_NVM_OP_STATUS: begin
          rdData_nxt = statusByte;
        end
        default: begin
          rdData_nxt = fpec_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN_r) begin
    if (!rstSyncN_r) begin
      rdData_r <= fpec_pkg::RDATA_RESET;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

endmodule

// *** verification/fpec_assertions.sv ***
// port-level checks for the program and erase controller
`timescale 1ns/1ps

module fpec_assertions (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic nvmDoneIrq
);
  logic [11:0] gapCnt_r;
  logic [11:0] gapCnt_nxt;

  // cycles since the last completion, saturating
  always_comb begin
    gapCnt_nxt = gapCnt_r;
    if (nvmDoneIrq) begin
      gapCnt_nxt = 12'h000;
    end else if (gapCnt_r != 12'hfff) begin
      gapCnt_nxt = gapCnt_r + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      gapCnt_r <= 12'hfff;
    end else begin
      gapCnt_r <= gapCnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence stsRd;
    regRdEn && regAddr == fpec_pkg::OFS_NVM_OP_STATUS;
  endsequence

  sequence lowWrThenRd;
    regWrEn && regAddr == fpec_pkg::OFS_NVM_ADDR_LOW
      ##2 regRdEn && regAddr == fpec_pkg::OFS_NVM_ADDR_LOW;
  endsequence

  rd_idle_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data not zero outside read answer");
  irq_pulse_a: assert property (nvmDoneIrq |=> !nvmDoneIrq)
    else $error("completion pulse longer than one cycle");
  irq_spacing_a: assert property (nvmDoneIrq |-> gapCnt_r >= 12'h200)
    else $error("completions closer than an operation time");
  key_hidden_a: assert property (
    regRdEn && regAddr == fpec_pkg::OFS_NVM_UNLOCK_KEY_PORT |=> regRdData == 8'h00)
    else $error("key port readable");
  trig_hidden_a: assert property (
    regRdEn && regAddr == fpec_pkg::OFS_NVM_PAGE_ERASE_TRIGGER |=> regRdData == 8'h00)
    else $error("erase trigger readable");
  sts_reserved_a: assert property (
    stsRd |=> regRdData[7:4] == 4'h0 && !regRdData[2])
    else $error("status unused bits set");
  done_status_a: assert property (
    stsRd ##0 nvmDoneIrq |=> !regRdData[3] && (regRdData[1] ^ regRdData[0]))
    else $error("status wrong at completion");
  addr_back_a: assert property (
    lowWrThenRd |=> regRdData == $past(regWrData, 3))
    else $error("address low byte readback differs");
endmodule

bind fpec_ctrl fpec_assertions fpec_assertions_inst (.clk_sys(clk_sys), .nrst(nrst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .nvmDoneIrq(nvmDoneIrq));

// *** verification/fpec_host.sv ***
// host processor model driving the register port
`timescale 1ns/1ps

module fpec_host (
  input wire logic clk_sys,
  input wire logic [7:0] regRdData,
  input wire logic nvmDoneIrq,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn
);
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end

  // released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    #1 d = regRdData;
  endtask

  task automatic setAddr(input logic [12:0] a);
    wr(fpec_pkg::OFS_NVM_ADDR_HIGH, {3'h0, a[12:8]});
    wr(fpec_pkg::OFS_NVM_ADDR_LOW, a[7:0]);
  endtask

  task automatic unlock();
    wr(fpec_pkg::OFS_NVM_UNLOCK_KEY_PORT, fpec_pkg::KEY_FIRST);
    wr(fpec_pkg::OFS_NVM_UNLOCK_KEY_PORT, fpec_pkg::KEY_SECOND);
  endtask

  // status read every cycle until the completion pulse
  task automatic pollDone(output logic seen, output logic [7:0] sts);
    int i;
    seen = 1'b0;
    @(posedge clk_sys);
    regAddr <= fpec_pkg::OFS_NVM_OP_STATUS;
    regRdEn <= 1'b1;
    for (i = 0; i < 2000 && !seen; i++) begin
      @(posedge clk_sys);
      #1 seen = (nvmDoneIrq === 1'b1);
    end
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    regAddr <= ~fpec_pkg::OFS_NVM_OP_STATUS;
    #1 sts = regRdData;
  endtask
endmodule

// *** verification/fpec_ctrl_bench.sv ***
// self-checking bench for the program and erase controller
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin \
  $display("Error %s expected %h seen %h", nm, exp, got); nErrors++; end end

module fpec_ctrl_bench;
  localparam int ERASE_N = 600;
  localparam logic [47:0] NET = 48'h0a1b2c3d4e5f; // arbitrary value
  logic clk_sys;
  logic nrst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regRdData;
  logic nvmDoneIrq;
  logic [7:0] d;
  int nErrors = 0;
  int samplesChecked = 0;

  fpec_ctrl #(.ERASE_CYCLES(ERASE_N), .FACTORY_NET_ADDR(NET)) fpec_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .nvmDoneIrq(nvmDoneIrq));
  fpec_host fpec_host_inst (.clk_sys(clk_sys), .regRdData(regRdData),
    .nvmDoneIrq(nvmDoneIrq), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic doReset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic waitOp(input logic [7:0] expSts);
    logic seen;
    logic [7:0] sts;
    fpec_host_inst.pollDone(seen, sts);
    `CHK("done", 1'b1, seen)
    if (seen !== 1'b1) begin
      wrap_up();
    end else begin
      `CHK("status", expSts, sts)
    end
  endtask

  task automatic rdByte(input logic [12:0] a, output logic [7:0] v);
    fpec_host_inst.setAddr(a);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, v);
  endtask

  task automatic testReset();
    logic [7:0] hid [3];
    hid = '{fpec_pkg::OFS_NVM_UNLOCK_KEY_PORT, fpec_pkg::OFS_NVM_PAGE_ERASE_TRIGGER, 8'h00};
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_OP_STATUS, d);
    `CHK("status reset", 8'h00, d)
    foreach (hid[i]) begin
      fpec_host_inst.rd(hid[i], d);
      `CHK("hidden", 8'h00, d)
    end
    fpec_host_inst.setAddr(13'h1ffa);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_ADDR_LOW, d);
    `CHK("addr low", 8'hfa, d)
    for (int i = 0; i < 6; i++) begin
      fpec_host_inst.rd(fpec_pkg::OFS_NVM_SEQUENTIAL_READ_PORT, d);
      `CHK("net byte", NET[47 - 8 * i -: 8], d)
    end
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_ADDR_HIGH, d);
    `CHK("addr high", 8'h20, d)
  endtask

  task automatic testWrite();
    fpec_host_inst.unlock();
    fpec_host_inst.setAddr(13'h0010);
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h5a);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_OP_STATUS, d);
    `CHK("busy", 1'b1, d[fpec_pkg::STS_BUSY_BIT])
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_ADDR_LOW, d);
    `CHK("addr while busy", 8'h10, d)
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h00);
    waitOp(8'h02);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, d);
    `CHK("byte", 8'h5a, d)
    fpec_host_inst.unlock();
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h0f);
    waitOp(8'h02);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, d);
    `CHK("and byte", 8'h0a, d)
  endtask

  task automatic testErase();
    fpec_host_inst.unlock();
    fpec_host_inst.setAddr(13'h1e05);
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_PAGE_ERASE_TRIGGER, 8'h02);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_OP_STATUS, d);
    `CHK("bad go", 8'h02, d)
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_PAGE_ERASE_TRIGGER, fpec_pkg::ERASE_GO);
    waitOp(8'h01);
    rdByte(13'h1fff, d);
    `CHK("page top", fpec_pkg::ERASED_BYTE, d)
    rdByte(13'h1e00, d);
    `CHK("page base", fpec_pkg::ERASED_BYTE, d)
    rdByte(13'h0010, d);
    `CHK("other page", 8'h0a, d)
  endtask

  task automatic testBar();
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h00);
    fpec_host_inst.unlock();
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h00);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_OP_STATUS, d);
    `CHK("barred", 8'h01, d)
    doReset();
    fpec_host_inst.unlock();
    fpec_host_inst.setAddr(13'h0010);
    // byte holds 0x0a, so its page is cleared before the rewrite
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_PAGE_ERASE_TRIGGER, fpec_pkg::ERASE_GO);
    waitOp(8'h01);
    fpec_host_inst.unlock();
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h00);
    waitOp(8'h02);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, d);
    `CHK("after reset", 8'h00, d)
    fpec_host_inst.wr(fpec_pkg::OFS_NVM_BYTE_DATA_PORT, 8'h00);
    fpec_host_inst.rd(fpec_pkg::OFS_NVM_OP_STATUS, d);
    `CHK("key spent", 8'h02, d)
  endtask

  initial begin
    nrst = 1'b0;
    doReset();
    testReset();
    testWrite();
    testErase();
    testBar();
    wrap_up();
  end
endmodule
